// file: dv/psled_lamps.sv
// model of the five indicator lamps on the driver's pins
// assumes each pin sinks current through a series resistor
`timescale 1ns/1ps
module psled_lamps (
  // driver pins, bit 0 is output one
  input wire logic [4:0] pin_n,
  // lamp state, high while lit
  output logic [4:0] lit
);
  // lamps sit between supply and pin, so a low pin lights them
  assign lit = ~pin_n;
endmodule // psled_lamps

// file: dv/test_psled_driver.sv
// self-checking bench of the status indicator driver
// assumes full-length blink counts, so only steady lamp states are compared
`timescale 1ns/1ps
module test_psled_driver
  import psled_pkg::*;
;
  // ****************************************
  // signals, design and lamps
  // ****************************************
  logic mclk = 1'h0;
  logic rst = 1'h1;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic avs_waitrequest;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic [31:0] rd;
  logic link_up = 1'h0;
  logic [1:0] link_speed = 2'h0;
  logic full_duplex = 1'h0;
  logic activity = 1'h0;
  logic collision = 1'h0;
  logic style_strap = 1'h1;
  logic [4:0] pins;
  logic [4:0] lit;
  int num_errors = 0;
  int n_checks = 0;

  psled_driver u_psled_driver (.mclk(mclk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .link_up(link_up),
    .link_speed(link_speed), .full_duplex(full_duplex),
    .activity(activity), .collision(collision), .style_strap(style_strap),
    .indicator_out_one(pins[0]), .indicator_out_two(pins[1]),
    .indicator_out_three(pins[2]), .indicator_out_four(pins[3]),
    .indicator_out_five(pins[4]));
  psled_lamps u_psled_lamps (.pin_n(pins), .lit(lit));

  initial begin
    forever #2 mclk = ~mclk;
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // request held until the edge that samples waitrequest low
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge mclk);
    end while (avs_waitrequest !== 1'h0);
    rd = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    bus(1'h1, a, d);
  endtask

  task automatic rd_reg(input logic [3:0] a);
    bus(1'h0, a, 32'h0);
  endtask

  // apply link state, wait out sync plus register, compare lamps and status
  task automatic look(input logic up, input logic [1:0] spd,
                      input logic fdx, input logic [1:0] sty,
                      input logic [4:0] exp);
    @(posedge mclk);
    link_up <= up;
    link_speed <= spd;
    full_duplex <= fdx;
    repeat (5) @(posedge mclk);
    chk({27'h0, lit}, {27'h0, ~exp});
    rd_reg(4'h4);
    chk(rd, {18'h0, exp, 1'h0, sty, 2'h0, fdx, spd, up});
  endtask

  task automatic do_reset(input logic strap, input int cyc);
    style_strap <= strap;
    rst <= 1'h1;
    repeat (cyc) @(posedge mclk);
    chk({27'h0, pins}, 32'h1F);
    rst <= 1'h0;
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    summarize();
  end

  initial begin
    do_reset(1'h1, 2);
    rd_reg(4'h0);
    chk(rd, 32'h7);
    wr_reg(4'h8, 32'hFFFFFFFF);
    rd_reg(4'h8);
    chk(rd, 32'h0);
    rd_reg(4'h0);
    chk(rd, 32'h7);
    look(1'h0, 2'h0, 1'h0, 2'h0, 5'h1F);
    for (int s = 0; s <= 3; s++) begin
      wr_reg(4'h0, 32'h4 | s);
      look(1'h1, 2'h1, 1'h1, 2'h0, (s == 0) ? 5'h1F : 5'h09);
    end
    look(1'h1, 2'h2, 1'h0, 2'h0, 5'h15);
    look(1'h1, 2'h0, 1'h1, 2'h0, 5'h19);
    wr_reg(4'h0, 32'h0F);
    look(1'h1, 2'h0, 1'h1, 2'h0, 5'h1F);
    wr_reg(4'h0, 32'h17);
    look(1'h1, 2'h0, 1'h1, 2'h0, 5'h1F);
    wr_reg(4'h0, 32'h03);
    look(1'h1, 2'h1, 1'h1, 2'h2, 5'h19);
    // strap flips right after release; only the captured value counts
    do_reset(1'h0, 4);
    style_strap <= 1'h1;
    look(1'h1, 2'h2, 1'h1, 2'h1, 5'h11);
    look(1'h1, 2'h2, 1'h1, 2'h1, 5'h11);
    look(1'h1, 2'h1, 1'h1, 2'h1, 5'h0A);
    look(1'h1, 2'h1, 1'h0, 2'h1, 5'h0E);
    look(1'h1, 2'h0, 1'h0, 2'h1, 5'h1C);
    look(1'h0, 2'h0, 1'h0, 2'h1, 5'h1F);
    wr_reg(4'h0, 32'h0F);
    look(1'h1, 2'h2, 1'h1, 2'h1, 5'h1F);
    wr_reg(4'h0, 32'h03);
    look(1'h1, 2'h1, 1'h1, 2'h2, 5'h19);
    // stretch outlasts the run, so this goes last; select 10b, 100 link
    wr_reg(4'h0, 32'h06);
    activity <= 1'h1;
    repeat (5) @(posedge mclk);
    activity <= 1'h0;
    repeat (5) @(posedge mclk);
    rd_reg(4'h4);
    chk({27'h0, rd[13:9]}, 32'h1B);
    chk({27'h0, lit}, 32'h04);
    // a stretched collision darkens output three in blink phase low
    collision <= 1'h1;
    repeat (5) @(posedge mclk);
    collision <= 1'h0;
    repeat (5) @(posedge mclk);
    chk({27'h0, pins}, 32'h1F);
    summarize();
  end
endmodule // test_psled_driver

// file: rtl/psled_defines.svh
// timing and encoding constants of the status indicator driver
// assumes inclusion from the package and the design module only
`ifndef PSLED_DEFINES_SVH
`define PSLED_DEFINES_SVH
// core clock rate in kHz and blink half period in ms
`define PSLED_CLK_KHZ 250000
`define PSLED_BLINK_HALF_MS 50
`define PSLED_BLINK_CYC (`PSLED_CLK_KHZ * `PSLED_BLINK_HALF_MS)
// activity and collision stretch time in ms
`define PSLED_STRETCH_MS 100
`define PSLED_STRETCH_CYC (`PSLED_CLK_KHZ * `PSLED_STRETCH_MS)
// register offsets (byte addresses, word index 0 and 1)
`define PSLED_OFF_CTRL 4'h0
`define PSLED_OFF_STAT 4'h4
// control field positions
`define PSLED_CTRL_SEL_LO 0
`define PSLED_CTRL_MODE 2
`define PSLED_CTRL_ISO 3
`define PSLED_CTRL_PDN 4
// control reset value: select 11b, mode bit 1
`define PSLED_CTRL_RST 5'h07
// line speed encodings
`define PSLED_SPD_10 2'h0
`define PSLED_SPD_100 2'h1
`define PSLED_SPD_1000 2'h2
`endif

// file: rtl/psled_driver.sv
// five status indicator outputs driven from link state, with an
// avalon-mm slave holding the control bits.
// assumes status inputs and the strap arrive from other clock domains.
`timescale 1ns/1ps
`include "psled_defines.svh"
module psled_driver
  import psled_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // link status, asynchronous
  input wire logic link_up,
  input wire logic [1:0] link_speed,
  input wire logic full_duplex,
  input wire logic activity,
  input wire logic collision,
  input wire logic style_strap,
  // indicator pins, active low
  output logic indicator_out_one,
  output logic indicator_out_two,
  output logic indicator_out_three,
  output logic indicator_out_four,
  output logic indicator_out_five
);

  // ***************************************************************
  // input synchronisers
  // ***************************************************************
  localparam int NSYNC = 7;
  logic [NSYNC-1:0] sync1_ff, nxt_sync1;
  logic [NSYNC-1:0] sync2_ff, nxt_sync2;
  always_comb begin
    nxt_sync1 = {style_strap, collision, activity, full_duplex,
                 link_speed, link_up};
    nxt_sync2 = sync1_ff;
  end
  // no reset on the chain: the strap level must already be through it
  // when reset lets go, since it is captured at the first edge after
  always_ff @(posedge mclk) begin
    sync1_ff <= nxt_sync1;
    sync2_ff <= nxt_sync2;
  end
  logic s_link, s_fdx, s_act, s_col, s_strap;
  logic [1:0] s_spd;
  assign s_link = sync2_ff[0];
  assign s_spd = sync2_ff[2:1];
  assign s_fdx = sync2_ff[3];
  assign s_act = sync2_ff[4];
  assign s_col = sync2_ff[5];
  assign s_strap = sync2_ff[6];

  // ***************************************************************
  // strap capture and control register
  // ***************************************************************
  // the strap is caught on the first clock after reset release
  logic strap_ff, nxt_strap;
  logic strap_done_ff, nxt_strap_done;
  logic [4:0] ctrl_ff, nxt_ctrl;
  logic wait_ff, nxt_wait;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0] sel;
  logic mode_bit, iso, pdn;
  psled_style_e style;
  logic [4:0] led_q_ff;

  assign sel = ctrl_ff[`PSLED_CTRL_SEL_LO +: 2];
  assign mode_bit = ctrl_ff[`PSLED_CTRL_MODE];
  assign iso = ctrl_ff[`PSLED_CTRL_ISO];
  assign pdn = ctrl_ff[`PSLED_CTRL_PDN];

  // one wait cycle per access; answer comes at second edge
  always_comb begin
    nxt_strap = strap_ff;
    nxt_strap_done = 1'b1;
    if (!strap_done_ff) begin
      nxt_strap = s_strap;
    end
    nxt_ctrl = ctrl_ff;
    nxt_rdata = rdata_ff;
    nxt_wait = 1'b0;
    // write lands at the edge that completes the transfer
    if (avs_write && wait_ff && avs_address == `PSLED_OFF_CTRL) begin
      nxt_ctrl = avs_writedata[4:0];
    end
    if ((avs_read || avs_write) && !wait_ff) begin
      nxt_wait = 1'b1;
      // status: pin levels, a spare zero, style, synchronised inputs
      case (avs_address)
        `PSLED_OFF_CTRL: nxt_rdata = {27'h0000000, ctrl_ff};
        `PSLED_OFF_STAT: nxt_rdata = {18'h00000, led_q_ff, 1'b0,
                                      style, s_col, s_act, s_fdx,
                                      s_spd, s_link};
        default: nxt_rdata = 32'h00000000;
      endcase
    end
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      strap_ff <= 1'b0;
      strap_done_ff <= 1'b0;
      ctrl_ff <= `PSLED_CTRL_RST;
      wait_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
    end else begin
      strap_ff <= nxt_strap;
      strap_done_ff <= nxt_strap_done;
      ctrl_ff <= nxt_ctrl;
      wait_ff <= nxt_wait;
      rdata_ff <= nxt_rdata;
    end
  end
  assign avs_waitrequest = (avs_read || avs_write) && !wait_ff;
  assign avs_readdata = rdata_ff;

  // ***************************************************************
  // style select
  // ***************************************************************
  // the strap only matters while the mode bit is set
  always_comb begin
    if (!mode_bit) begin
      style = PSLED_STY_ENH;
    end else if (strap_ff) begin
      style = PSLED_STY_INDIV;
    end else begin
      style = PSLED_STY_TRI;
    end
  end

  // ***************************************************************
  // blink timer and event stretchers
  // ***************************************************************
  localparam logic [31:0] BLINK_CYC = 32'(`PSLED_BLINK_CYC);
  localparam logic [31:0] STRETCH_CYC = 32'(`PSLED_STRETCH_CYC);
  logic [31:0] blink_cnt_ff, nxt_blink_cnt;
  logic phase_ff, nxt_phase;
  logic [31:0] act_cnt_ff, nxt_act_cnt;
  logic [31:0] col_cnt_ff, nxt_col_cnt;
  logic act_vis, col_vis;
  // a single short event would vanish unseen, so hold it for a while
  always_comb begin
    nxt_blink_cnt = blink_cnt_ff + 32'h1;
    nxt_phase = phase_ff;
    if (blink_cnt_ff >= BLINK_CYC - 32'h1) begin
      nxt_blink_cnt = 32'h0;
      nxt_phase = ~phase_ff;
    end
    nxt_act_cnt = (act_cnt_ff != 32'h0) ? act_cnt_ff - 32'h1 : 32'h0;
    if (s_act) begin
      nxt_act_cnt = STRETCH_CYC;
    end
    nxt_col_cnt = (col_cnt_ff != 32'h0) ? col_cnt_ff - 32'h1 : 32'h0;
    if (s_col) begin
      nxt_col_cnt = STRETCH_CYC;
    end
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      blink_cnt_ff <= 32'h0;
      phase_ff <= 1'b0;
      act_cnt_ff <= 32'h0;
      col_cnt_ff <= 32'h0;
    end else begin
      blink_cnt_ff <= nxt_blink_cnt;
      phase_ff <= nxt_phase;
      act_cnt_ff <= nxt_act_cnt;
      col_cnt_ff <= nxt_col_cnt;
    end
  end
  assign act_vis = s_act || (act_cnt_ff != 32'h0);
  assign col_vis = s_col || (col_cnt_ff != 32'h0);

  // ***************************************************************
  // indicator decode; bit 0 is output one, 1 means lamp lit
  // ***************************************************************
  logic [4:0] lit, nxt_led_q;
  logic l10, l100, l1000, blink_act;
  assign l10 = s_link && s_spd == `PSLED_SPD_10;
  assign l100 = s_link && s_spd == `PSLED_SPD_100;
  assign l1000 = s_link && s_spd == `PSLED_SPD_1000;
  assign blink_act = act_vis ? phase_ff : 1'b1;
  always_comb begin
    lit = 5'h00;
    if (sel != 2'h0) begin
      lit[4] = l100 && ((sel == 2'h2) ? blink_act : 1'b1);
      lit[3] = l1000 && ((sel == 2'h2) ? blink_act : 1'b1);
      // collision blink overrides the duplex level
      lit[2] = col_vis ? phase_ff : (s_link && s_fdx);
      lit[1] = s_link;
      lit[0] = act_vis && phase_ff;
    end
    case (style)
      PSLED_STY_TRI: begin
        // only outputs one and two change here
        lit[1] = (l1000 || l10) && blink_act;
        lit[0] = (l100 || l10) && blink_act;
      end
      PSLED_STY_ENH: begin
        // enhanced functions are outside this block; five is disabled
        lit[4] = 1'b0;
      end
      default: begin
      end
    endcase
    if (iso || pdn) begin
      lit = 5'h00;
    end
    nxt_led_q = ~lit;
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      led_q_ff <= 5'h1F;
    end else begin
      led_q_ff <= nxt_led_q;
    end
  end
  assign indicator_out_one = led_q_ff[0];
  assign indicator_out_two = led_q_ff[1];
  assign indicator_out_three = led_q_ff[2];
  assign indicator_out_four = led_q_ff[3];
  assign indicator_out_five = led_q_ff[4];

  // ***************************************************************
  // checks
  // ***************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_iso_forces_off: assert property (
    iso |=> led_q_ff == 5'h1F) else $error("isolate not off");
  a_pdn_forces_off: assert property (
    pdn |=> led_q_ff == 5'h1F) else $error("power-down not off");
  a_enh_five_off: assert property (
    !mode_bit |=> indicator_out_five) else $error("five lit in enh");
  a_enh_style_sel: assert property (
    !mode_bit && !iso && !pdn && sel != 2'h0 && s_link |=>
      !indicator_out_two) else $error("enh ignores strap");
  a_tri_nolink_high: assert property (
    style == PSLED_STY_TRI && !s_link |=>
      indicator_out_one && indicator_out_two) else $error("tri nolink");
  a_fdx_three_on: assert property (
    style != PSLED_STY_ENH && !iso && !pdn && sel != 2'h0 && s_link &&
      s_fdx && !col_vis |=> !indicator_out_three)
    else $error("three not on");
  a_tri_1000_one: assert property (
    style == PSLED_STY_TRI && l1000 && !iso && !pdn |=>
      indicator_out_one) else $error("one lit at 1000");
  a_rsvd_sel_off: assert property (
    style == PSLED_STY_INDIV && sel == 2'h0 |=> led_q_ff == 5'h1F)
    else $error("reserved select lit");
  a_tri_10_both: assert property (
    style == PSLED_STY_TRI && l10 && !act_vis && !iso && !pdn |=>
      !indicator_out_one && !indicator_out_two) else $error("tri 10 dark");
  a_tri_100_one: assert property (
    style == PSLED_STY_TRI && l100 && !act_vis && !iso && !pdn |=>
      !indicator_out_one && indicator_out_two) else $error("tri 100 bad");

  // a link held for three samples has crossed the synchroniser
  sequence s_link_held;
    (link_up && !iso && !pdn && sel != 2'h0 &&
      style != PSLED_STY_TRI) [*3];
  endsequence
  a_link_two_on: assert property (
    s_link_held |=> !indicator_out_two) else $error("two not on");

  // one event sample then quiet: only the stretch keeps it visible, and
  // with the blink phase low the lamp must be dark
  sequence s_act_gone;
    s_act ##1 (!s_act && sel == 2'h2 && l100 && !phase_ff &&
      style != PSLED_STY_ENH && !iso && !pdn);
  endsequence
  a_act_stretch: assert property (
    s_act_gone |=> indicator_out_five) else $error("activity lost");

  sequence s_col_gone;
    s_col ##1 (!s_col && !phase_ff && sel != 2'h0 && !iso && !pdn);
  endsequence
  a_col_stretch: assert property (
    s_col_gone |=> indicator_out_three) else $error("collision lost");
endmodule // psled_driver

// file: rtl/psled_pkg.sv
// types of the status indicator driver
// assumes psled_defines.svh is on the include path
package psled_pkg;
  `include "psled_defines.svh"
  typedef enum logic [1:0] {
    PSLED_STY_INDIV,
    PSLED_STY_TRI,
    PSLED_STY_ENH
  } psled_style_e;
  typedef enum logic [1:0] {
    PSLED_BUS_IDLE,
    PSLED_BUS_ACK
  } psled_bus_e;
endpackage
